/* File: verilog/sfg_guard.sv */
// Slave command logic: identification reads, hold, power-up guard, write guards.
// Assumes SPI mode 0 or 3 pins that are asynchronous to clock_i.
`timescale 1ns/100ps
`include "sfg_map.svh"
module sfg_guard
    import sfg_pkg::*;
#(
    parameter int PU_READ_CYC = `SFG_PU_READ_CYC,
    parameter int PU_WRITE_CYC = `SFG_PU_WRITE_CYC
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire sfg_pkg::sfg_pins_t pins_i,
    input wire logic busy_i,
    output logic so_o,
    output logic so_oe_o,
    output logic held_o,
    output logic pwr_down_o,
    output logic read_ready_o,
    output logic write_ready_o,
    output logic cmd_valid_o,
    output sfg_pkg::sfg_cmd_t cmd_o
);
    import sfg_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    sfg_pins_t pins_s;
    sfg_pins_t pins_d_r;
    sfg_sync #(.WIDTH(4)) u_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .async_i(pins_i),
        .sync_o(pins_s)
    );

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pins_d_r <= 4'hf;
        end else begin
            pins_d_r <= pins_s;
        end
    end

    logic cs_act;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    logic hold_fall;
    logic hold_rise;
    assign cs_act = !pins_s.cs_n;
    assign cs_rise = pins_s.cs_n && !pins_d_r.cs_n;
    assign sck_rise = pins_s.sck && !pins_d_r.sck;
    assign sck_fall = !pins_s.sck && pins_d_r.sck;
    assign hold_fall = !pins_s.hold_n && pins_d_r.hold_n;
    assign hold_rise = pins_s.hold_n && !pins_d_r.hold_n;

    // ------------------------------------------------------------
    // Power-on timers
    // ------------------------------------------------------------
    // Reset stands in for the supply ramp; writes stay blocked until count
    logic [31:0] pu_cnt_r;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pu_cnt_r <= 32'h0;
            read_ready_o <= 1'b0;
            write_ready_o <= 1'b0;
        end else begin
            if (!write_ready_o) begin
                pu_cnt_r <= pu_cnt_r + 32'h1;
            end
            if (pu_cnt_r >= 32'(PU_READ_CYC)) begin
                read_ready_o <= 1'b1;
            end
            if (pu_cnt_r >= 32'(PU_WRITE_CYC)) begin
                write_ready_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Hold
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            held_o <= 1'b0;
        end else if (!cs_act) begin
            held_o <= 1'b0;
        end else if (hold_fall && !pins_s.sck) begin
            held_o <= 1'b1;
        end else if (hold_rise) begin
            held_o <= 1'b0;
        end
    end

    logic step_in;
    logic step_out;
    assign step_in = cs_act && !held_o && sck_rise;
    assign step_out = cs_act && !held_o && sck_fall;

    // ------------------------------------------------------------
    // Shift and command sequencing
    // ------------------------------------------------------------
    function automatic logic is_write_op(input logic [7:0] op);
        return op == `SFG_OP_PAGE_PROG || op == `SFG_OP_STATUS_WR ||
            op == `SFG_OP_SSEC_ERASE || op == `SFG_OP_SEC_ERASE ||
            op == `SFG_OP_CHIP_ERASE;
    endfunction

    sfg_state_t state_r;
    logic [2:0] bit_r;
    logic [15:0] byte_r;
    logic [7:0] shift_r;
    logic [7:0] opcode_r;
    logic [7:0] tx_r;
    logic alt_part_r;
    logic [7:0] rx_nxt;
    assign rx_nxt = {shift_r[6:0], pins_s.si};

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            bit_r <= 3'h0;
            byte_r <= 16'h0;
            shift_r <= 8'h0;
        end else if (!cs_act) begin
            bit_r <= 3'h0;
            byte_r <= 16'h0;
        end else if (step_in) begin
            shift_r <= rx_nxt;
            bit_r <= bit_r + 3'h1;
            if (bit_r == 3'h7 && byte_r != 16'hffff) begin
                byte_r <= byte_r + 16'h1;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            opcode_r <= 8'h0;
            alt_part_r <= 1'b0;
        end else if (!cs_act) begin
            state_r <= pins_s.cs_n ? ST_IDLE : state_r;
        end else if (step_in && bit_r == 3'h7) begin
            case (state_r)
                ST_IDLE, ST_OPCODE: begin
                    opcode_r <= rx_nxt;
                    if (!read_ready_o) begin
                        state_r <= ST_SINK;
                    end else if (busy_i && (rx_nxt == `SFG_OP_ID_JEDEC ||
                                            rx_nxt == `SFG_OP_ID_ALT)) begin
                        state_r <= ST_SINK;
                    end else if (rx_nxt == `SFG_OP_ID_JEDEC) begin
                        state_r <= ST_ID_OUT;
                        alt_part_r <= 1'b0;
                    end else if (rx_nxt == `SFG_OP_ID_ALT) begin
                        state_r <= ST_ALT_ADDR;
                    end else begin
                        state_r <= ST_SINK;
                    end
                end
                ST_ALT_ADDR: begin
                    if (byte_r == 16'(`SFG_ALT_ID_BYTES - 1)) begin
                        state_r <= ST_ID_OUT;
                        alt_part_r <= rx_nxt[0];
                    end
                end
                ST_ID_OUT: begin
                    alt_part_r <= !alt_part_r;
                end
                ST_SINK: begin
                    state_r <= ST_SINK;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Serial output
    // ------------------------------------------------------------
    logic [7:0] id_code;
    logic so_live_r;
    assign id_code = alt_part_r ? `SFG_PART_CODE : `SFG_MAKER_CODE;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            so_o <= 1'b0;
            so_oe_o <= 1'b0;
            so_live_r <= 1'b0;
            tx_r <= 8'h0;
        end else if (!cs_act || state_r != ST_ID_OUT) begin
            so_oe_o <= 1'b0;
            so_o <= 1'b0;
            so_live_r <= 1'b0;
        end else if (held_o) begin
            // Floats only; the launched bit is kept for the end of the hold
            so_oe_o <= 1'b0;
        end else if (step_out) begin
            so_oe_o <= 1'b1;
            so_live_r <= 1'b1;
            if (bit_r == 3'h0) begin
                so_o <= id_code[7];
                tx_r <= {id_code[6:0], 1'b0};
            end else begin
                so_o <= tx_r[7];
                tx_r <= {tx_r[6:0], 1'b0};
            end
        end else begin
            so_oe_o <= so_live_r;
        end
    end

    // ------------------------------------------------------------
    // Power-down exit and write command guard
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pwr_down_o <= 1'b0;
        end else if (step_in && bit_r == 3'h7 && byte_r == 16'h0) begin
            if (rx_nxt == `SFG_OP_ID_ALT) begin
                pwr_down_o <= 1'b0;
            end else if (rx_nxt == `SFG_OP_PWR_DOWN && !busy_i) begin
                pwr_down_o <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_valid_o <= 1'b0;
            cmd_o <= '0;
        end else begin
            cmd_valid_o <= cs_rise && byte_r != 16'h0;
            if (cs_rise) begin
                cmd_o.opcode <= opcode_r;
                cmd_o.write_ok <= is_write_op(opcode_r) && bit_r == 3'h0 &&
                    write_ready_o && !pwr_down_o;
                cmd_o.pp_ok <= opcode_r == `SFG_OP_PAGE_PROG && bit_r == 3'h0 &&
                    byte_r > 16'h4;
                cmd_o.sr_ok <= opcode_r == `SFG_OP_STATUS_WR && bit_r == 3'h0 &&
                    byte_r == 16'h2;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    held_float_a: assert property (@(posedge clock_i) disable iff (rst_i)
        held_o |=> !so_oe_o) else $error("output driven while held");
    cs_clear_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !cs_act |=> !held_o) else $error("hold kept with cs high");
    busy_no_id_a: assert property (@(posedge clock_i) disable iff (rst_i)
        busy_i && step_in && bit_r == 3'h7 && byte_r == 16'h0 |=> state_r != ST_ID_OUT)
        else $error("id accepted while busy");
    off_byte_a: assert property (@(posedge clock_i) disable iff (rst_i)
        cs_rise && bit_r != 3'h0 |=> !cmd_o.write_ok) else $error("partial write accepted");
    sr_long_a: assert property (@(posedge clock_i) disable iff (rst_i)
        cs_rise && byte_r > 16'h2 |=> !cmd_o.sr_ok) else $error("long status write accepted");
    pu_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !write_ready_o && cs_rise |=> !cmd_o.write_ok) else $error("write before power-up");
    alt_exit_a: assert property (@(posedge clock_i) disable iff (rst_i)
        step_in && bit_r == 3'h7 && byte_r == 16'h0 && rx_nxt == `SFG_OP_ID_ALT
        |=> !pwr_down_o) else $error("power-down kept after alt id");
    id_toggle_a: assert property (@(posedge clock_i) disable iff (rst_i)
        state_r == ST_ID_OUT && step_in && bit_r == 3'h7 |=> alt_part_r != $past(alt_part_r))
        else $error("id code did not alternate");
    cs_end_a: assert property (@(posedge clock_i) disable iff (rst_i)
        cs_rise |=> ##1 !so_oe_o) else $error("output kept after cs rise");
    hold_resume_a: assert property (@(posedge clock_i) disable iff (rst_i)
        $fell(held_o) && cs_act && so_live_r |=> so_oe_o)
        else $error("output lost after hold");
    cov_jedec_c: cover property (@(posedge clock_i) disable iff (rst_i)
        state_r == ST_ID_OUT && opcode_r == `SFG_OP_ID_JEDEC);
    cov_alt_c: cover property (@(posedge clock_i) disable iff (rst_i)
        state_r == ST_ID_OUT && opcode_r == `SFG_OP_ID_ALT);
    cov_hold_c: cover property (@(posedge clock_i) disable iff (rst_i) held_o);
    cov_write_c: cover property (@(posedge clock_i) disable iff (rst_i)
        cmd_valid_o && cmd_o.write_ok);
endmodule // sfg_guard

/* File: verilog/sfg_map.svh */
// Constants for the serial flash identification and hold guard.
// Assumes inclusion by the package, the guard module and the bench.
`ifndef SFG_MAP_SVH
`define SFG_MAP_SVH
`define SFG_OP_ID_JEDEC 8'h9f
`define SFG_OP_ID_ALT 8'hab
`define SFG_OP_PAGE_PROG 8'h02
`define SFG_OP_STATUS_WR 8'h01
`define SFG_OP_SSEC_ERASE 8'hd7
`define SFG_OP_SEC_ERASE 8'hd8
`define SFG_OP_CHIP_ERASE 8'hc7
`define SFG_OP_WR_ENABLE 8'h06
`define SFG_OP_WR_DISABLE 8'h04
`define SFG_OP_PWR_DOWN 8'hb9
// Maker and part codes: arbitrary neutral values
`define SFG_MAKER_CODE 8'h5a
`define SFG_PART_CODE 8'ha5
`define SFG_ALT_ID_BYTES 4
`define SFG_CLK_MHZ 250
`define SFG_PU_READ_US 100
`define SFG_PU_WRITE_MS 10
`define SFG_PU_READ_CYC (`SFG_PU_READ_US * `SFG_CLK_MHZ)
`define SFG_PU_WRITE_CYC (`SFG_PU_WRITE_MS * 1000 * `SFG_CLK_MHZ)
`endif

/* File: verilog/sfg_pkg.sv */
// Types shared by the serial flash guard modules.
// Assumes sfg_map.svh is on the include path.
`include "sfg_map.svh"
package sfg_pkg;
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic hold_n;
    } sfg_pins_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic write_ok;
        logic pp_ok;
        logic sr_ok;
    } sfg_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OPCODE = 3'b001,
        ST_ALT_ADDR = 3'b010,
        ST_ID_OUT = 3'b011,
        ST_SINK = 3'b100
    } sfg_state_t;
endpackage

/* File: verilog/sfg_sync.sv */
// Two-stage synchroniser for the asynchronous pin bundle.
// Assumes pins come from outside the clock_i domain.
`timescale 1ns/100ps
module sfg_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_r;
    // Resets to all ones, the idle level of select and hold
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= '1;
            sync_o <= '1;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule // sfg_sync

/* File: test/sfg_host.sv */
// Host SPI master model driving the guard's pins in mode 0.
// Assumes a 4 ns clock_i; SCK is built from 4-clock halves (16 ns each, 32 ns period).
`timescale 1ns/100ps
module sfg_host
    import sfg_pkg::*;
(
    input wire logic clock_i,
    input wire logic so_i,
    output sfg_pkg::sfg_pins_t pins_o
);
    // ----------------------------------------
    // Pin driving tasks
    // ----------------------------------------
    initial begin
        pins_o = 4'b1001; // Select high, SCK low, hold high at power-up
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock_i);
    endtask

    task automatic frame_begin();
        @(posedge clock_i);
        pins_o.cs_n <= 1'b0;
        wait_clk(4);
    endtask

    // SCK stands still low between frames; SI shows inverse once released
    task automatic frame_end();
        wait_clk(4);
        pins_o.cs_n <= 1'b1;
        pins_o.si <= ~pins_o.si;
        wait_clk(8);
    endtask

    // Shifts bits hi..lo; SO sampled late in the high phase for margin
    task automatic xfer_bits(input logic [7:0] tx, input int hi, input int lo,
                             inout logic [7:0] rx);
        for (int i = hi; i >= lo; i--) begin
            @(posedge clock_i);
            pins_o.si <= tx[i]; // MSB first, set while SCK low
            wait_clk(3);
            pins_o.sck <= 1'b1;
            wait_clk(4);
            rx[i] = so_i;
            pins_o.sck <= 1'b0;
        end
    endtask

    task automatic set_hold(input logic v);
        @(posedge clock_i);
        pins_o.hold_n <= v; // Only ever moved while SCK is low
    endtask
endmodule // sfg_host

/* File: test/serial_flash_id_hold_guard_tb.sv */
// Self-checking bench for the serial flash guard with a host model.
// Assumes sfg_map.svh on the include path; short power-up counts.
`timescale 1ns/100ps
`include "sfg_map.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module serial_flash_id_hold_guard_tb;
    import sfg_pkg::*;
    // ----------------------------------------
    // Harness
    // ----------------------------------------
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic busy_i = 1'b0;
    sfg_pins_t pins;
    logic so_o, so_oe_o, held_o, pwr_down_o, read_ready_o, write_ready_o, cmd_valid_o;
    sfg_cmd_t cmd_o, cmd_r;
    int err_count = 0, checks = 0, n_cmd = 0, n_oe = 0;
    logic [7:0] mk = `SFG_MAKER_CODE, pt = `SFG_PART_CODE;
    always #2 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        if (cmd_valid_o === 1'b1) begin
            cmd_r <= cmd_o;
            n_cmd <= n_cmd + 1;
        end
        if (so_oe_o === 1'b1) n_oe <= n_oe + 1;
    end
    sfg_guard #(.PU_READ_CYC(20), .PU_WRITE_CYC(400)) dut (.clock_i(clock_i), .rst_i(rst_i),
        .pins_i(pins), .busy_i(busy_i), .so_o(so_o), .so_oe_o(so_oe_o), .held_o(held_o),
        .pwr_down_o(pwr_down_o), .read_ready_o(read_ready_o), .write_ready_o(write_ready_o),
        .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o));
    // Undriven SO shows the inverse of the design's last bit
    sfg_host host (.clock_i(clock_i), .so_i(so_oe_o === 1'b1 ? so_o : ~so_o), .pins_o(pins));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic wait_rdy(input int w, output int n);
        n = 0;
        while (((w == 0) ? read_ready_o : write_ready_o) !== 1'b1) begin
            if (n++ > 2000) begin
                err_count++;
                complete_run();
            end
            @(posedge clock_i);
        end
    endtask

    // Sends nb bytes; the last one carries only lb bits
    task automatic send(input logic [7:0] op, input int nb, input int lb);
        logic [7:0] rx;
        host.frame_begin();
        for (int i = 0; i < nb; i++)
            host.xfer_bits((i == 0) ? op : 8'h3c, 7, (i == nb - 1) ? 8 - lb : 0, rx);
        host.frame_end();
    endtask

    task automatic id_read(input logic [7:0] op, input logic a0, input logic [7:0] first);
        logic [7:0] rx;
        host.frame_begin();
        host.xfer_bits(op, 7, 0, rx);
        if (op == `SFG_OP_ID_ALT)
            for (int i = 0; i < 3; i++) host.xfer_bits((i == 2) ? {7'h00, a0} : 8'h00, 7, 0, rx);
        for (int k = 0; k < 4; k++) begin
            host.xfer_bits(8'h00, 7, 0, rx);
            `CHK("id_byte", (k % 2 == 0) ? first : (first ^ mk ^ pt), rx)
        end
        host.frame_end();
        `CHK("oe_after_cs", 1'b0, so_oe_o)
        $display("test id_read %h done", op);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_power();
        int n;
        `CHK("read_ready_early", 1'b0, read_ready_o)
        wait_rdy(0, n);
        `CHK("read_wait", 1'b1, n >= 18)
        `CHK("write_ready_early", 1'b0, write_ready_o)
        send(`SFG_OP_STATUS_WR, 2, 8);
        `CHK("early_write_ok", 1'b0, cmd_r.write_ok)
        wait_rdy(1, n);
        $display("test power done");
    endtask

    task automatic t_busy();
        int base;
        busy_i <= 1'b1;
        base = n_oe;
        send(`SFG_OP_ID_JEDEC, 2, 8);
        `CHK("busy_oe", base, n_oe)
        busy_i <= 1'b0;
        $display("test busy done");
    endtask

    task automatic t_hold();
        logic [7:0] rx, junk;
        host.frame_begin();
        host.xfer_bits(`SFG_OP_ID_JEDEC, 7, 0, junk);
        host.xfer_bits(8'h00, 7, 3, rx);
        host.set_hold(1'b0);
        host.wait_clk(8);
        `CHK("held_on", 1'b1, held_o)
        `CHK("held_oe", 1'b0, so_oe_o)
        host.xfer_bits(8'hff, 3, 2, junk);
        host.set_hold(1'b1);
        host.wait_clk(8);
        `CHK("held_off", 1'b0, held_o)
        host.xfer_bits(8'h00, 2, 0, rx);
        `CHK("held_byte", mk, rx)
        host.set_hold(1'b0);
        host.frame_end();
        `CHK("cs_clears_hold", 1'b0, held_o)
        host.set_hold(1'b1);
        $display("test hold done");
    endtask

    task automatic t_write();
        logic [7:0] op[9] = '{8'h02, 8'h02, 8'h02, 8'h01, 8'h01, 8'hc7, 8'hc7, 8'hd8, 8'hd8};
        int nb[9] = '{5, 5, 4, 2, 3, 1, 2, 4, 4};
        int lb[9] = '{8, 3, 8, 8, 8, 8, 5, 8, 6};
        int sel[9] = '{1, 1, 1, 2, 2, 0, 0, 0, 0};
        logic ex[9] = '{1, 0, 0, 1, 0, 1, 0, 1, 0};
        int base;
        logic got;
        for (int r = 0; r < 9; r++) begin
            base = n_cmd;
            send(op[r], nb[r], lb[r]);
            `CHK("cmd_pulse", base + 1, n_cmd)
            `CHK("cmd_opcode", op[r], cmd_r.opcode)
            got = (sel[r] == 0) ? cmd_r.write_ok : (sel[r] == 1) ? cmd_r.pp_ok : cmd_r.sr_ok;
            `CHK("cmd_ok", ex[r], got)
        end
        $display("test write done");
    endtask

    task automatic t_pdown();
        send(`SFG_OP_PWR_DOWN, 1, 8);
        `CHK("pdown_set", 1'b1, pwr_down_o)
        send(`SFG_OP_ID_ALT, 1, 8);
        `CHK("pdown_exit", 1'b0, pwr_down_o)
        $display("test pdown done");
    endtask

    initial begin
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        t_power();
        id_read(`SFG_OP_ID_JEDEC, 1'b0, mk);
        id_read(`SFG_OP_ID_ALT, 1'b0, mk);
        id_read(`SFG_OP_ID_ALT, 1'b1, pt);
        t_busy();
        t_hold();
        t_write();
        t_pdown();
        complete_run();
    end

    initial begin
        #200000;
        err_count++;
        complete_run();
    end
endmodule // serial_flash_id_hold_guard_tb
